// ==== pkg/fssu_regs.svh ====
/*
 * Constants of the flexible serial shift unit: widths, reset values,
 * counter limits and clock ratios.
 * Assumes inclusion by bare name ahead of any user of these constants.
 */
// Overview of operation
// - eight-bit shift register, CPU readable and writable, no buffer behind it
// - shift register msb drives one of two output pins per wire mode
// - output latch changes data on the edge opposite to sampling
// - serial input always sampled from the serial input pin
// - four-bit counter, CPU readable and writable, raises overflow
// - shift register and counter advance together from one clock source
// - external clock: counter advances on both rising and falling edges
// - clock source: serial clock pin, timer zero overflow or software strobe
// - two-wire start condition detection raises a flag
// - two-wire mode: clock pin held low after start condition or counter overflow
// - three-wire mode acts as SPI modes 0 and 1, no slave select
// - linked units exchange register contents after eight clock cycles
// - master toggles serial clock pin on each toggle strobe
// - edge select 0: sample rising, shift falling; 1: the opposite
// - sixteen counted edges overflow the counter and set the overflow flag
// - counter overflow wakes the processor from idle sleep
// - two-wire mode wakes the processor from every sleep mode
`ifndef FSSU_REGS_SVH
`define FSSU_REGS_SVH

`define SR_WIDTH 8
`define SR_MSB 7
`define CNT_WIDTH 4
`define SR_RESET 8'h00
`define CNT_RESET 4'h0
`define CNT_LAST 4'hF
`define CNT_STEP 4'h1
`define MASTER_SCK_DIV 2
`define SLAVE_SCK_DIV 4

`endif

// ==== pkg/fssu_pkg.sv ====
/*
 * Types of the flexible serial shift unit.
 * Assumes fssu_regs.svh is on the include path.
 */
`include "fssu_regs.svh"

package fssu_pkg;

    typedef enum logic [1:0] {
        SRC_SOFTWARE,
        SRC_TIMER_ZERO,
        SRC_PIN
    } clock_source_type;

    typedef enum logic {
        WIRE_THREE,
        WIRE_TWO
    } wire_mode_type;

    typedef struct packed {
        logic bit_v;
        logic tgl;
    } link_state_type;

endpackage

// ==== hdl/link_edge_capture.sv ====
/*
 * Link-side capture of the serial input on one edge of the serial clock.
 * Assumes the caller feeds the clock inverted for the falling edge and
 * that the serial clock runs during reset.
 */
`timescale 1ns/1ps

module link_edge_capture
    import fssu_pkg::*;
(
    input wire logic link_clk_i,
    input wire logic rstn_i,
    input wire logic serial_in_pin_i,
    output logic bit_o,
    output logic tgl_o
);

    link_state_type q, d;

    // ****************************************
    // capture and event toggle
    // ****************************************
    always_comb begin
        d = q;
        d.bit_v = serial_in_pin_i;
        d.tgl = ~q.tgl;
        if (!rstn_i) begin
            d = '0;
        end
    end

    always_ff @(posedge link_clk_i) begin
        q <= d;
    end

    assign bit_o = q.bit_v;
    assign tgl_o = q.tgl;

endmodule

// ==== hdl/flexible_serial_shift_unit.sv ====
/*
 * Flexible serial shift unit: 8-bit shift register, 4-bit edge counter,
 * three-wire and two-wire pin handling, start detection and clock hold.
 * Assumes CPU-side strobes are on clk_i; the serial clock pin is a
 * clock of its own and runs no faster than clk_i/4 when slave.
 */
`timescale 1ns/1ps
`include "fssu_regs.svh"

module flexible_serial_shift_unit
    import fssu_pkg::*;
(
    input wire logic clk_i,
    input wire logic rstn_i,
    input wire logic sck_i,
    input wire logic serial_in_pin_i,
    input wire logic sda_i,
    input wire logic [7:0] data_i,
    input wire logic data_wr_i,
    input wire logic [3:0] counter_i,
    input wire logic counter_wr_i,
    input wire clock_source_type clock_source_i,
    input wire wire_mode_type wire_mode_i,
    input wire logic clock_edge_select_i,
    input wire logic master_i,
    input wire logic clock_toggle_i,
    input wire logic clock_strobe_i,
    input wire logic timer_zero_ovf_i,
    input wire logic data_drive_i,
    input wire logic hold_enable_i,
    input wire logic overflow_clear_i,
    input wire logic start_clear_i,
    output logic [7:0] data_o,
    output logic [3:0] counter_o,
    output logic overflow_flag_o,
    output logic start_flag_o,
    output logic wake_o,
    output logic serial_out_pin_o,
    output logic serial_out_pin_oe_o,
    output logic sda_o,
    output logic sda_oe_o,
    output logic serial_clock_pin_o,
    output logic serial_clock_pin_oe_o
);

    // ****************************************
    // state
    // ****************************************
    typedef struct packed {
        logic rise_s1;
        logic rise_s2;
        logic rise_p;
        logic fall_s1;
        logic fall_s2;
        logic fall_p;
        logic rbit_s1;
        logic rbit_s2;
        logic fbit_s1;
        logic fbit_s2;
        logic di_s1;
        logic di_s2;
        logic sda_s1;
        logic sda_s2;
        logic sda_p;
        logic scl_s1;
        logic scl_s2;
        logic smp;
        logic [7:0] sr;
        logic [3:0] cnt;
        logic out_bit;
        logic ovf;
        logic start;
        logic mclk;
        logic sck_out;
        logic sck_oe;
        logic do_v;
        logic do_oe;
        logic sda_v;
        logic sda_oe;
        logic wake;
    } unit_state_type;

    unit_state_type q, d;

    logic rise_tgl;
    logic fall_tgl;
    logic rise_bit;
    logic fall_bit;
    logic sck_n;

    logic rise_ev;
    logic fall_ev;
    logic tgl_ev;
    logic edge_rise;
    logic edge_fall;
    logic edge_bit;
    logic samp;
    logic shft;
    logic strobe;
    logic ev_count;
    logic ovf_set;
    logic start_det;
    logic d_hold;
    logic [4:0] step;

    // ****************************************
    // helpers
    // ****************************************
    function automatic logic [7:0] shift_in(input logic [7:0] sr, input logic b);
        shift_in = {sr[6:0], b};
    endfunction

    function automatic logic [4:0] count_step(input logic [3:0] c);
        if (c == `CNT_LAST) begin
            count_step = {1'b1, `CNT_RESET};
        end else begin
            count_step = {1'b0, c + `CNT_STEP};
        end
    endfunction

    // ****************************************
    // link side capture
    // ****************************************
    assign sck_n = ~sck_i;

    link_edge_capture u_rise (
        .link_clk_i(sck_i),
        .rstn_i(rstn_i),
        .serial_in_pin_i(serial_in_pin_i),
        .bit_o(rise_bit),
        .tgl_o(rise_tgl)
    );

    link_edge_capture u_fall (
        .link_clk_i(sck_n),
        .rstn_i(rstn_i),
        .serial_in_pin_i(serial_in_pin_i),
        .bit_o(fall_bit),
        .tgl_o(fall_tgl)
    );

    // ****************************************
    // next state
    // ****************************************
    always_comb begin
        d = q;
        d.rise_s1 = rise_tgl;
        d.rise_s2 = q.rise_s1;
        d.rise_p = q.rise_s2;
        d.fall_s1 = fall_tgl;
        d.fall_s2 = q.fall_s1;
        d.fall_p = q.fall_s2;
        d.rbit_s1 = rise_bit;
        d.rbit_s2 = q.rbit_s1;
        d.fbit_s1 = fall_bit;
        d.fbit_s2 = q.fbit_s1;
        d.di_s1 = serial_in_pin_i;
        d.di_s2 = q.di_s1;
        d.sda_s1 = sda_i;
        d.sda_s2 = q.sda_s1;
        d.sda_p = q.sda_s2;
        d.scl_s1 = sck_i;
        d.scl_s2 = q.scl_s1;

        // edges seen by the unit
        rise_ev = q.rise_s2 ^ q.rise_p;
        fall_ev = q.fall_s2 ^ q.fall_p;
        tgl_ev = clock_toggle_i & master_i;
        if (tgl_ev) begin
            d.mclk = ~q.mclk;
        end
        if (master_i) begin
            edge_rise = tgl_ev & ~q.mclk;
            edge_fall = tgl_ev & q.mclk;
            edge_bit = q.di_s2;
        end else begin
            edge_rise = rise_ev;
            edge_fall = fall_ev;
            edge_bit = rise_ev ? q.rbit_s2 : q.fbit_s2;
        end

        // clock source selection
        samp = 1'b0;
        shft = 1'b0;
        strobe = 1'b0;
        unique case (clock_source_i)
            SRC_PIN: begin
                if (!clock_edge_select_i) begin
                    samp = edge_rise;
                    shft = edge_fall;
                end else begin
                    samp = edge_fall;
                    shft = edge_rise;
                end
            end
            SRC_TIMER_ZERO: begin
                strobe = timer_zero_ovf_i;
            end
            SRC_SOFTWARE: begin
                strobe = clock_strobe_i;
            end
            default: begin
                strobe = 1'b0;
            end
        endcase
        ev_count = samp | shft | strobe;

        // sampling edge shifts, output latch follows on the opposite edge
        if (samp) begin
            d.smp = edge_bit;
            d.sr = shift_in(q.sr, edge_bit);
        end
        if (shft) begin
            d.out_bit = q.sr[`SR_MSB];
        end
        if (strobe) begin
            d.sr = shift_in(q.sr, q.di_s2);
            d.out_bit = d.sr[`SR_MSB];
        end
        if (data_wr_i) begin
            d.sr = data_i;
            d.out_bit = data_i[`SR_MSB];
        end

        // edge counter
        step = count_step(q.cnt);
        ovf_set = 1'b0;
        if (ev_count) begin
            d.cnt = step[3:0];
            ovf_set = step[4];
        end
        if (counter_wr_i) begin
            d.cnt = counter_i;
            ovf_set = 1'b0;
        end

        // flags, set wins over clear
        if (overflow_clear_i) begin
            d.ovf = 1'b0;
        end
        if (ovf_set) begin
            d.ovf = 1'b1;
        end
        start_det = (wire_mode_i == WIRE_TWO) & q.scl_s2 & q.sda_p & ~q.sda_s2;
        if (start_clear_i) begin
            d.start = 1'b0;
        end
        if (start_det) begin
            d.start = 1'b1;
        end

        // clock pin and wait states
        d_hold = (wire_mode_i == WIRE_TWO) & hold_enable_i & (d.start | d.ovf);
        d.sck_oe = master_i | d_hold;
        d.sck_out = d_hold ? 1'b0 : d.mclk;

        // data pins
        if (wire_mode_i == WIRE_THREE) begin
            d.do_v = d.out_bit;
            d.do_oe = data_drive_i;
            d.sda_oe = 1'b0;
        end else begin
            d.do_v = 1'b0;
            d.do_oe = 1'b0;
            d.sda_oe = ~d.out_bit;
        end
        d.sda_v = 1'b0;

        // wakeup
        d.wake = d.ovf | ((wire_mode_i == WIRE_TWO) & d.start);

        if (!rstn_i) begin
            d = '0;
            d.sr = `SR_RESET;
            d.cnt = `CNT_RESET;
        end
    end

    always_ff @(posedge clk_i) begin
        q <= d;
    end

    // ****************************************
    // outputs
    // ****************************************
    assign data_o = q.sr;
    assign counter_o = q.cnt;
    assign overflow_flag_o = q.ovf;
    assign start_flag_o = q.start;
    assign wake_o = q.wake;
    assign serial_out_pin_o = q.do_v;
    assign serial_out_pin_oe_o = q.do_oe;
    assign sda_o = q.sda_v;
    assign sda_oe_o = q.sda_oe;
    assign serial_clock_pin_o = q.sck_out;
    assign serial_clock_pin_oe_o = q.sck_oe;

    // ****************************************
    // assertions
    // ****************************************
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (!rstn_i);

    property p_data_write;
        data_wr_i |=> data_o == $past(data_i);
    endproperty
    a_data_write: assert property (p_data_write) else $error("data write lost");

    property p_wrap;
        ev_count && q.cnt == `CNT_LAST && !counter_wr_i
            |=> counter_o == `CNT_RESET && overflow_flag_o;
    endproperty
    a_wrap: assert property (p_wrap) else $error("counter did not wrap");

    property p_ovf_cause;
        $rose(overflow_flag_o) |-> $past(q.cnt) == `CNT_LAST && $past(ev_count);
    endproperty
    a_ovf_cause: assert property (p_ovf_cause) else $error("overflow without 16th edge");

    property p_set_wins;
        ovf_set && overflow_clear_i |=> overflow_flag_o;
    endproperty
    a_set_wins: assert property (p_set_wins) else $error("overflow set lost to clear");

    property p_count_edge;
        samp && !shft && !counter_wr_i |=> counter_o == $past(counter_o) + `CNT_STEP;
    endproperty
    a_count_edge: assert property (p_count_edge) else $error("sample edge not counted");

    property p_strobe_shift;
        strobe && !data_wr_i && !counter_wr_i
            |=> data_o[0] == $past(q.di_s2) && counter_o == $past(counter_o) + `CNT_STEP;
    endproperty
    a_strobe_shift: assert property (p_strobe_shift) else $error("strobe shift mismatch");

    property p_edge_sel;
        clock_source_i == SRC_PIN && !master_i && !clock_edge_select_i && rise_ev && !fall_ev
            |=> q.smp == $past(q.rbit_s2);
    endproperty
    a_edge_sel: assert property (p_edge_sel) else $error("rising edge not sampled");

    property p_toggle;
        tgl_ev && !d_hold |=> serial_clock_pin_o == !$past(q.mclk) && serial_clock_pin_oe_o;
    endproperty
    a_toggle: assert property (p_toggle) else $error("clock pin did not toggle");

    property p_hold;
        d_hold |=> serial_clock_pin_oe_o && !serial_clock_pin_o;
    endproperty
    a_hold: assert property (p_hold) else $error("clock pin not held low");

    property p_route;
        wire_mode_i == WIRE_THREE
            |=> serial_out_pin_o == q.out_bit && serial_out_pin_oe_o == $past(data_drive_i) && !sda_oe_o;
    endproperty
    a_route: assert property (p_route) else $error("msb routed to wrong pin");

    property p_latch;
        $changed(q.out_bit) |-> $past(shft || strobe || data_wr_i);
    endproperty
    a_latch: assert property (p_latch) else $error("output changed off shift edge");

    property p_start;
        start_det |=> start_flag_o ##1 (start_flag_o || $past(start_clear_i));
    endproperty
    a_start: assert property (p_start) else $error("start condition not flagged");

    property p_wake;
        $rose(overflow_flag_o) |-> wake_o;
    endproperty
    a_wake: assert property (p_wake) else $error("overflow did not wake");

    c_overflow: cover property (ovf_set);
    c_start: cover property (start_det ##1 d_hold);
    c_pin_byte: cover property (clock_source_i == SRC_PIN && samp ##[1:40] shft);

endmodule

// ==== dv/spi_master_model.sv ====
/*
 * Behavioural three-wire master at the far side of the shift unit.
 * Assumes the unit is slave in edge mode 0 or 1; clock kept under clk/4.
 */
`timescale 1ns/1ps

module spi_master_model (
    input wire logic miso_i,
    output logic sck_o,
    output logic mosi_o
);
    // ****************************************
    // link timebase, 30 ns
    // ****************************************
    localparam int HALF_TICKS = 20;
    logic link_clk = 1'b0;

    always #15 link_clk = ~link_clk;

    task automatic wait_ticks(input int n);
        repeat (n) @(posedge link_clk);
    endtask

    task automatic set_idle(input logic level);
        sck_o = level;
    endtask

    // edges for the link capture reset, then clock stands still
    initial begin
        sck_o = 1'b0;
        mosi_o = 1'b0;
        repeat (2) begin
            wait_ticks(5);
            sck_o = 1'b1;
            wait_ticks(5);
            sck_o = 1'b0;
        end
    end

    // ****************************************
    // one byte, mode 0 or 1, msb first
    // ****************************************
    task automatic transfer(input logic mode, input logic [7:0] tx, output logic [7:0] rx);
        mosi_o = tx[7];
        wait_ticks(HALF_TICKS);
        for (int i = 7; i >= 0; i--) begin
            if (!mode) begin
                rx[i] = miso_i;
            end
            sck_o = 1'b1;
            if (mode) begin
                mosi_o = tx[i];
            end
            wait_ticks(HALF_TICKS);
            if (mode) begin
                rx[i] = miso_i;
            end
            sck_o = 1'b0;
            if (!mode) begin
                mosi_o = (i > 0) ? tx[i-1] : ~tx[0];
            end
            wait_ticks(HALF_TICKS);
        end
    endtask
endmodule

// ==== dv/flexible_serial_shift_unit_tb_top.sv ====
/*
 * Self-checking bench of the flexible serial shift unit.
 * Assumes the master model in spi_master_model.sv on the link side.
 */
`timescale 1ns/1ps

module flexible_serial_shift_unit_tb_top;
    import fssu_pkg::*;
    // ****************************************
    // stimulus and wiring
    // ****************************************
    localparam logic [6:0] DWR = 7'h01, CWR = 7'h02, TGL = 7'h04, STB = 7'h08;
    localparam logic [6:0] TMR = 7'h10, OCL = 7'h20, SCL = 7'h40;
    logic clk_i = 1'b0, rstn_i = 1'b0, sda_i = 1'b1, edge_sel = 1'b0;
    logic master = 1'b0, drive = 1'b0, hold_en = 1'b0, miso_last = 1'b0;
    logic [6:0] pls = 7'h00;
    logic [7:0] din = 8'h00, rx;
    logic [3:0] cin = 4'h0;
    clock_source_type src = SRC_SOFTWARE;
    wire_mode_type wmode = WIRE_THREE;
    logic sck, mosi, miso, so, so_oe, ovf, stf, wake, scp, scp_oe, sda_oe, sda_out;
    logic [7:0] dout;
    logic [3:0] cnt;
    int mismatches = 0, checked = 0, cycles = 0;
    logic [7:0] txs [2] = '{8'hC5, 8'h00};
    logic [7:0] dvs [2] = '{8'h3C, 8'hFF};

    always #50 clk_i = ~clk_i;
    always @(posedge clk_i) if (so_oe) miso_last <= so;
    assign miso = so_oe ? so : ~miso_last;

    flexible_serial_shift_unit u_flexible_serial_shift_unit (
        .clk_i(clk_i), .rstn_i(rstn_i), .sck_i(sck), .serial_in_pin_i(mosi),
        .sda_i(sda_i), .data_i(din), .data_wr_i(pls[0]), .counter_i(cin),
        .counter_wr_i(pls[1]), .clock_source_i(src), .wire_mode_i(wmode),
        .clock_edge_select_i(edge_sel), .master_i(master), .clock_toggle_i(pls[2]),
        .clock_strobe_i(pls[3]), .timer_zero_ovf_i(pls[4]), .data_drive_i(drive),
        .hold_enable_i(hold_en), .overflow_clear_i(pls[5]), .start_clear_i(pls[6]),
        .data_o(dout), .counter_o(cnt), .overflow_flag_o(ovf), .start_flag_o(stf),
        .wake_o(wake), .serial_out_pin_o(so), .serial_out_pin_oe_o(so_oe),
        .sda_o(sda_out), .sda_oe_o(sda_oe), .serial_clock_pin_o(scp),
        .serial_clock_pin_oe_o(scp_oe)
    );

    spi_master_model u_spi_master_model (.miso_i(miso), .sck_o(sck), .mosi_o(mosi));

    // ****************************************
    // tasks
    // ****************************************
    task automatic pulse(input logic [6:0] m, input logic [7:0] d, input logic [3:0] c);
        @(posedge clk_i);
        pls <= m;
        din <= d;
        cin <= c;
        @(posedge clk_i);
        pls <= 7'h00;
        @(negedge clk_i);
    endtask

    task automatic check(input logic ok, input string msg);
        checked++;
        if (ok !== 1'b1) begin
            mismatches++;
            $display("CHECK FAILED %0t %s", $time, msg);
        end
    endtask

    task automatic wrap_up();
        if (mismatches == 0 && checked > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    always @(posedge clk_i) begin
        cycles++;
        if (cycles == 5000) begin
            mismatches++;
            wrap_up();
        end
    end

    // ****************************************
    // scenarios
    // ****************************************
    initial begin
        repeat (8) @(posedge clk_i);
        rstn_i <= 1'b1;
        @(negedge clk_i);
        check(dout === 8'h00 && cnt === 4'h0 && ovf === 1'b0, "reset values");
        pulse(DWR, 8'hA5, 4'h0);
        check(dout === 8'hA5 && so === 1'b1, "data write");
        pulse(CWR, 8'hA5, 4'hE);
        pulse(STB, 8'hA5, 4'hE);
        check(cnt === 4'hF && dout === 8'h4A, "strobe shift and count");
        pulse(STB, 8'hA5, 4'hE);
        check(cnt === 4'h0 && ovf === 1'b1 && wake === 1'b1, "wrap");
        pulse(OCL, 8'hA5, 4'h0);
        check(ovf === 1'b0, "overflow clear");
        @(posedge clk_i);
        src <= SRC_TIMER_ZERO;
        pulse(CWR | STB, 8'hA5, 4'h0);
        pulse(STB, 8'hA5, 4'h0);
        check(cnt === 4'h0, "strobe ignored on timer source");
        pulse(TMR, 8'hA5, 4'h0);
        check(cnt === 4'h1, "timer step");
        @(posedge clk_i);
        src <= SRC_PIN;
        master <= 1'b1;
        pulse(CWR, 8'hA5, 4'h0);
        pulse(TGL, 8'hA5, 4'h0);
        check(scp === 1'b1 && scp_oe === 1'b1, "toggle high");
        pulse(TGL, 8'hA5, 4'h0);
        repeat (2) @(negedge clk_i);
        check(scp === 1'b0 && cnt === 4'h2, "two edges counted");
        @(posedge clk_i);
        master <= 1'b0;
        drive <= 1'b1;
        for (int k = 0; k < 4; k++) begin
            @(posedge clk_i);
            edge_sel <= (k > 1);
            pulse(OCL | DWR, dvs[k % 2], 4'h0);
            pulse(CWR, dvs[k % 2], 4'h0);
            check(so_oe === 1'b1 && so === dvs[k % 2][7], "output set up");
            u_spi_master_model.transfer(k > 1, txs[k % 2], rx);
            repeat (8) @(negedge clk_i);
            check(dout === txs[k % 2] && rx === dvs[k % 2], "byte exchange");
            check(ovf === 1'b1 && cnt === 4'h0, "byte complete");
        end
        @(posedge clk_i);
        drive <= 1'b0;
        repeat (2) @(negedge clk_i);
        check(so_oe === 1'b0, "data output released");
        @(posedge clk_i);
        wmode <= WIRE_TWO;
        pulse(OCL | DWR, 8'h00, 4'h0);
        check(sda_oe === 1'b1 && sda_out === 1'b0 && so === 1'b0, "two-wire data low");
        pulse(DWR, 8'h80, 4'h0);
        check(sda_oe === 1'b0 && so_oe === 1'b0, "two-wire data released");
        u_spi_master_model.set_idle(1'b1);
        @(posedge clk_i);
        hold_en <= 1'b1;
        repeat (8) @(negedge clk_i);
        check(scp_oe === 1'b0 && stf === 1'b0, "no hold before start");
        @(posedge clk_i);
        sda_i <= 1'b0;
        repeat (8) @(negedge clk_i);
        check(stf === 1'b1 && wake === 1'b1, "start detected");
        check(scp_oe === 1'b1 && scp === 1'b0, "clock held low");
        wrap_up();
    end
endmodule
